//--- verilog/bringup_pkg.sv
// Constants shared by the reset and clock bring-up sequencer
package bringup_pkg;
  // Pin and spread settings
  localparam int GP_PIN_COUNT = 83;
  localparam int SPREAD_W = 2;
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  localparam logic [1:0] SPREAD_HALF = 2'h1;
  localparam logic [1:0] SPREAD_FULL = 2'h2;
  // Spread depths in tenths of a percent, centre spread
  localparam logic [3:0] SPREAD_DEPTH_HALF = 4'h5;
  localparam logic [3:0] SPREAD_DEPTH_FULL = 4'ha;
  // Triangle ramp: steps per half period at full and half depth
  localparam int RAMP_W = 8;
  localparam logic [7:0] RAMP_PEAK_FULL = 8'h64;
  localparam logic [7:0] RAMP_PEAK_HALF = 8'h32;
  // Primary PLL bring-up wait at power-up
  localparam int PLL_START_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_START_CYCLES = (PLL_START_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  // Reset values
  localparam logic RST_ASSERTED = 1'b0;
  localparam logic RST_RELEASED = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_PLL_UP  = 3'b001,
    ST_SYS_RST = 3'b010,
    ST_RUN     = 3'b011
  } seq_state_t;
endpackage : bringup_pkg

//--- verilog/reset_sync.sv
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/100ps
`default_nettype none
module reset_sync
  import bringup_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic clk_in,
  input wire logic nrst_async_in,
  output logic nrst_sync_out
);
  if (STAGES < 2) begin : g_bad_stages
    $error("reset_sync needs two stages at least");
  end

  logic [STAGES-1:0] chain_r;

  always_ff @(posedge clk_in or negedge nrst_async_in) begin
    if (!nrst_async_in) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], 1'b1};
    end
  end

  assign nrst_sync_out = chain_r[STAGES-1];
endmodule : reset_sync
`default_nettype wire

//--- verilog/reset_clock_bringup.sv
// Reset and clock bring-up sequencer of the display controller
// How it works
// RULE1 - At power-up the primary PLL is started first, then normal power mode, then the common reset sequence; the code enters both in one cycle.
// RULE2 - Every reset source returns the device to normal power mode with no software action.
// RULE3 - During and right after system reset all general-purpose pins are high impedance.
// RULE4 - The primary PLL keeps running through all resets except power-up, which alone resets it.
// RULE5 - Leaving system reset releases only the processor and its peripheral resets; the rest wait for software. The code releases only cpu_nrst_out.
// RULE6 - After reset the processor domain clocks run at full rate.
// RULE7 - After reset all front-end clocks are off until software enables them.
// RULE8 - After reset the display link PLL is powered down, its clocks stopped and its resets asserted.
// RULE9 - After reset the differential link drivers are powered down with outputs in high impedance.
// RULE10 - Every reset driven out of the device stays asserted until the processor releases it.
// RULE11 - After system reset the processor fetches boot code from external flash.
// RULE12 - Firmware programs rates, enables the link PLL with dividers held, and waits for lock.
// RULE13 - Releasing the divider resets starts all link clocks; firmware then releases external resets.
// RULE14 - Link clock spreading is triangular centre spread of 0, 0.5 or 1.0 percent only.
// RULE15 - All 83 general-purpose pins default to inputs; alternate functions stay in reset except clocks and PWM.
// RULE16 - Reset sources are merged and synchronised: assert at once, release on the clock. In the code a pin source asserts it on the fifth clock edge.
`timescale 1ns/100ps
`default_nettype none
module reset_clock_bringup
  import bringup_pkg::*;
#(
  parameter int GPIO_N = GP_PIN_COUNT,
  parameter int PLL_WAIT = PLL_START_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Reset sources
  input wire logic power_good_input_in,
  input wire logic watchdog_expired_in,
  input wire logic lamp_strike_in,
  // Firmware controls
  input wire logic front_clk_en_in,
  input wire logic display_link_pll_en_in,
  input wire logic display_link_pll_lock_in,
  input wire logic divider_release_in,
  input wire logic ext_reset_release_in,
  input wire logic periph_reset_release_in,
  input wire logic lvds_power_on_in,
  input wire logic [1:0] spread_sel_in,
  input wire logic gpio_release_in,
  // Power and clock state
  output logic primary_pll_run_out,
  output logic normal_power_out,
  output logic cpu_nrst_out,
  output logic cpu_full_rate_out,
  output logic boot_from_flash_out,
  output logic front_clk_en_out,
  output logic display_link_pll_pd_out,
  output logic divider_nrst_out,
  output logic link_clk_en_out,
  output logic lvds_pd_out,
  output logic lvds_oe_n_out,
  output logic [3:0] spread_depth_out,
  output logic [RAMP_W-1:0] spread_ramp_out,
  output logic periph_nrst_out,
  output logic ext_nrst_out,
  // General-purpose pin control
  output logic [GPIO_N-1:0] gpio_oe_n_out,
  output logic alt_func_nrst_out,
  output logic clk_pwm_alt_en_out
);
  if (GPIO_N < 1) begin : g_bad_gpio_n
    $error("GPIO_N must be positive");
  end
  if (PLL_WAIT < 1) begin : g_bad_pll_wait
    $error("PLL_WAIT must be at least one");
  end

  // ********************************************************
  // Reset source merge and synchronisation
  // ********************************************************
  logic [2:0] pg_sync_r;
  logic [2:0] wd_sync_r;
  logic [2:0] ls_sync_r;
  logic por_nrst;
  logic sys_nrst;
  logic src_fault_r;

  // Power-up reset alone clears the PLL start logic
  reset_sync #(.STAGES(SYNC_STAGES)) u_por_sync (
    .clk_in(mclk_in),
    .nrst_async_in(nrst_in),
    .nrst_sync_out(por_nrst)
  ); // RULE16

  // Pin sources pass three flops; stages 2 and 3 must agree
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pg_sync_r <= 3'h0;
      wd_sync_r <= 3'h0;
      ls_sync_r <= 3'h0;
    end else begin
      pg_sync_r <= {pg_sync_r[1:0], power_good_input_in};
      wd_sync_r <= {wd_sync_r[1:0], watchdog_expired_in};
      ls_sync_r <= {ls_sync_r[1:0], lamp_strike_in};
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_fault_r <= 1'b1;
    end else if (pg_sync_r[2] == pg_sync_r[1] &&
                 wd_sync_r[2] == wd_sync_r[1] &&
                 ls_sync_r[2] == ls_sync_r[1]) begin
      src_fault_r <= !pg_sync_r[2] || wd_sync_r[2] || ls_sync_r[2]; // RULE2
    end
  end

  // ********************************************************
  // Bring-up sequencer
  // ********************************************************
  seq_state_t state_r;
  logic [31:0] wait_r;
  logic pll_up_r;

  // Primary PLL state only ever reset by power-up
  always_ff @(posedge mclk_in or negedge por_nrst) begin
    if (!por_nrst) begin
      state_r <= ST_POR;
      wait_r <= 32'h0000_0000;
      pll_up_r <= 1'b0;
    end else begin
      case (state_r)
        ST_POR: begin
          state_r <= ST_PLL_UP; // RULE1
          wait_r <= 32'h0000_0000;
        end
        ST_PLL_UP: begin
          pll_up_r <= 1'b1; // RULE4
          if (wait_r == 32'(PLL_WAIT - 1)) begin
            state_r <= ST_SYS_RST; // RULE1
          end else begin
            wait_r <= wait_r + 32'h0000_0001;
          end
        end
        ST_SYS_RST: begin
          if (!src_fault_r) state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (src_fault_r) state_r <= ST_SYS_RST; // RULE2
        end
        default: state_r <= ST_POR;
      endcase
    end
  end

  // Merged system reset: any source asserts it, release is clocked
  // Registered so a multi-bit state change cannot glitch the async reset
  logic sys_run_r;
  always_ff @(posedge mclk_in or negedge por_nrst) begin
    if (!por_nrst) begin
      sys_run_r <= 1'b0;
    end else begin
      sys_run_r <= (state_r == ST_RUN) && !src_fault_r; // RULE16
    end
  end

  reset_sync #(.STAGES(SYNC_STAGES)) u_sys_sync (
    .clk_in(mclk_in),
    .nrst_async_in(sys_run_r),
    .nrst_sync_out(sys_nrst)
  ); // RULE16

  // ********************************************************
  // Power and processor domain
  // ********************************************************
  always_ff @(posedge mclk_in or negedge por_nrst) begin
    if (!por_nrst) begin
      primary_pll_run_out <= 1'b0;
      normal_power_out <= 1'b0;
    end else begin
      primary_pll_run_out <= pll_up_r; // RULE4
      normal_power_out <= pll_up_r; // RULE1 RULE2
    end
  end

  always_ff @(posedge mclk_in or negedge sys_nrst) begin
    if (!sys_nrst) begin
      cpu_nrst_out <= RST_ASSERTED;
      cpu_full_rate_out <= 1'b1; // RULE6
      boot_from_flash_out <= 1'b1; // RULE11
    end else begin
      cpu_nrst_out <= RST_RELEASED; // RULE5
      cpu_full_rate_out <= 1'b1;
      boot_from_flash_out <= 1'b1;
    end
  end

  // ********************************************************
  // Software-released domains
  // ********************************************************
  // Firmware strobes are sampled only once the processor runs
  always_ff @(posedge mclk_in or negedge sys_nrst) begin
    if (!sys_nrst) begin
      front_clk_en_out <= 1'b0; // RULE7
      periph_nrst_out <= RST_ASSERTED; // RULE5
      ext_nrst_out <= RST_ASSERTED; // RULE10
      gpio_oe_n_out <= '1; // RULE3 RULE15
      alt_func_nrst_out <= RST_ASSERTED; // RULE15
      clk_pwm_alt_en_out <= 1'b1;
    end else begin
      front_clk_en_out <= front_clk_en_in;
      periph_nrst_out <= periph_reset_release_in;
      // External resets follow the divider release
      ext_nrst_out <= ext_reset_release_in && divider_nrst_out; // RULE13
      gpio_oe_n_out <= '1;
      alt_func_nrst_out <= gpio_release_in;
      clk_pwm_alt_en_out <= 1'b1;
    end
  end

  // Link PLL powers up only on request; dividers wait for lock
  always_ff @(posedge mclk_in or negedge sys_nrst) begin
    if (!sys_nrst) begin
      display_link_pll_pd_out <= 1'b1; // RULE8
      divider_nrst_out <= RST_ASSERTED; // RULE8
      link_clk_en_out <= 1'b0;
      lvds_pd_out <= 1'b1; // RULE9
      lvds_oe_n_out <= 1'b1; // RULE9
    end else begin
      display_link_pll_pd_out <= !display_link_pll_en_in; // RULE12
      divider_nrst_out <= divider_release_in && display_link_pll_en_in
                          && display_link_pll_lock_in; // RULE12
      link_clk_en_out <= divider_nrst_out; // RULE13
      lvds_pd_out <= !(lvds_power_on_in && divider_nrst_out);
      lvds_oe_n_out <= !(lvds_power_on_in && divider_nrst_out);
    end
  end

  // ********************************************************
  // Triangular centre spread
  // ********************************************************
  logic [RAMP_W-1:0] ramp_r;
  logic ramp_up_r;
  logic [RAMP_W-1:0] peak;

  // Unsupported codes fall back to no spread
  always_comb begin
    case (spread_sel_in)
      SPREAD_HALF: peak = RAMP_PEAK_HALF;
      SPREAD_FULL: peak = RAMP_PEAK_FULL;
      default: peak = '0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge sys_nrst) begin
    if (!sys_nrst) begin
      ramp_r <= '0;
      ramp_up_r <= 1'b1;
      spread_depth_out <= 4'h0;
      spread_ramp_out <= '0;
    end else begin
      case (spread_sel_in)
        SPREAD_HALF: spread_depth_out <= SPREAD_DEPTH_HALF; // RULE14
        SPREAD_FULL: spread_depth_out <= SPREAD_DEPTH_FULL; // RULE14
        default: spread_depth_out <= 4'h0;
      endcase
      if (!link_clk_en_out || peak == '0) begin
        ramp_r <= '0;
        ramp_up_r <= 1'b1;
      end else if (ramp_up_r) begin
        if (ramp_r >= peak) ramp_up_r <= 1'b0;
        else ramp_r <= ramp_r + 1'b1; // RULE14
      end else begin
        if (ramp_r == '0) ramp_up_r <= 1'b1;
        else ramp_r <= ramp_r - 1'b1; // RULE14
      end
      spread_ramp_out <= ramp_r;
    end
  end
endmodule : reset_clock_bringup
`default_nettype wire

//--- verification/bringup_chk.sv
// Checker for the bring-up sequencer ports
`timescale 1ns/100ps
`default_nettype none
module bringup_chk
  import bringup_pkg::*;
#(
  parameter int GPIO_N = GP_PIN_COUNT
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic watchdog_expired_in,
  input wire logic display_link_pll_en_in,
  input wire logic display_link_pll_lock_in,
  input wire logic [1:0] spread_sel_in,
  input wire logic primary_pll_run_out,
  input wire logic cpu_nrst_out,
  input wire logic display_link_pll_pd_out,
  input wire logic divider_nrst_out,
  input wire logic link_clk_en_out,
  input wire logic [3:0] spread_depth_out,
  input wire logic ext_nrst_out,
  input wire logic [GPIO_N-1:0] gpio_oe_n_out
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  chk_pll_stays_on: assert property (primary_pll_run_out |=>
    primary_pll_run_out) else $error("primary pll stopped");
  chk_gpio_all_in: assert property (gpio_oe_n_out == {GPIO_N{1'b1}})
    else $error("gpio driven");
  chk_link_after_div: assert property ($rose(link_clk_en_out) |->
    divider_nrst_out) else $error("link clock before dividers");
  chk_ext_after_div: assert property ($rose(ext_nrst_out) |->
    divider_nrst_out) else $error("external reset early");
  chk_div_needs_lock: assert property ($rose(divider_nrst_out) |->
    $past(display_link_pll_lock_in) && $past(display_link_pll_en_in))
    else $error("dividers released without lock");
  chk_pd_until_en: assert property ($fell(display_link_pll_pd_out) |->
    $past(display_link_pll_en_in) && cpu_nrst_out) else $error("pll up early");
  chk_src_resets: assert property (watchdog_expired_in |->
    ##[0:8] !cpu_nrst_out) else $error("watchdog ignored");
  chk_spread_half: assert property (cpu_nrst_out && $past(cpu_nrst_out) &&
    spread_sel_in == SPREAD_HALF |=> !cpu_nrst_out ||
    spread_depth_out == SPREAD_DEPTH_HALF) else $error("spread depth");
  cov_link_up: cover property ($rose(link_clk_en_out));
  cov_ext_up: cover property ($rose(ext_nrst_out));
  cov_src_rst: cover property ($fell(cpu_nrst_out));
endmodule : bringup_chk
bind reset_clock_bringup bringup_chk #(.GPIO_N(GPIO_N)) u_chk (.mclk_in,
  .nrst_in, .watchdog_expired_in, .display_link_pll_en_in,
  .display_link_pll_lock_in, .spread_sel_in, .primary_pll_run_out,
  .cpu_nrst_out, .display_link_pll_pd_out, .divider_nrst_out,
  .link_clk_en_out, .spread_depth_out, .ext_nrst_out, .gpio_oe_n_out);
`default_nettype wire

//--- verification/lock_model.sv
// Display link PLL lock behaviour seen by firmware
`timescale 1ns/100ps
`default_nettype none
module lock_model #(
  parameter int LOCK_DELAY = 6
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic pll_pd_in,
  output logic lock_out
);
  int cnt;
  // Lock only after a settling time; cleared at the first clock edge while powered down
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in || pll_pd_in) begin
      cnt <= 0;
      lock_out <= 1'b0;
    end else if (cnt < LOCK_DELAY) begin
      cnt <= cnt + 1;
    end else begin
      lock_out <= 1'b1;
    end
  end
endmodule : lock_model
`default_nettype wire

//--- verification/reset_clock_bringup_tb.sv
// Self-checking bench for the reset and clock bring-up sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_clock_bringup_tb;
  import bringup_pkg::*;
  logic mclk_in, nrst_in, power_good_input_in, watchdog_expired_in;
  logic lamp_strike_in, front_clk_en_in, display_link_pll_en_in, lock;
  logic divider_release_in, ext_reset_release_in, periph_reset_release_in;
  logic lvds_power_on_in, gpio_release_in;
  logic [1:0] spread_sel_in;
  logic pll_run, npwr, cpu_n, full, flash, fclk, pd, div_n, lclk, lpd, loe_n;
  logic per_n, ext_n, alt_n, pwm;
  logic [3:0] dep;
  logic [RAMP_W-1:0] ramp;
  logic [GP_PIN_COUNT-1:0] oe_n;
  int err_total, n_checks, cycles;
  reset_clock_bringup #(.PLL_WAIT(4)) dut (.mclk_in, .nrst_in,
    .power_good_input_in, .watchdog_expired_in, .lamp_strike_in,
    .front_clk_en_in, .display_link_pll_en_in,
    .display_link_pll_lock_in(lock), .divider_release_in,
    .ext_reset_release_in, .periph_reset_release_in, .lvds_power_on_in,
    .spread_sel_in, .gpio_release_in, .primary_pll_run_out(pll_run),
    .normal_power_out(npwr), .cpu_nrst_out(cpu_n), .cpu_full_rate_out(full),
    .boot_from_flash_out(flash), .front_clk_en_out(fclk),
    .display_link_pll_pd_out(pd), .divider_nrst_out(div_n),
    .link_clk_en_out(lclk), .lvds_pd_out(lpd), .lvds_oe_n_out(loe_n),
    .spread_depth_out(dep), .spread_ramp_out(ramp), .periph_nrst_out(per_n),
    .ext_nrst_out(ext_n), .gpio_oe_n_out(oe_n), .alt_func_nrst_out(alt_n),
    .clk_pwm_alt_en_out(pwm));
  lock_model u_lock (.mclk_in, .nrst_in, .pll_pd_in(pd), .lock_out(lock));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(string nm, logic [GP_PIN_COUNT-1:0] seen,
                     logic [GP_PIN_COUNT-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic fw(logic v);
    {front_clk_en_in, display_link_pll_en_in, divider_release_in} <= {3{v}};
    {ext_reset_release_in, periph_reset_release_in} <= {2{v}};
    {lvds_power_on_in, gpio_release_in} <= {2{v}};
  endtask : fw
  task automatic wait_cpu(logic lvl);
    int i;
    for (i = 0; i < 100 && cpu_n !== lvl; i++) @(negedge mclk_in);
    chk("cpu_nrst", cpu_n, lvl);
  endtask : wait_cpu
  task automatic summarize;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // ****************
  // Scenarios
  // ****************
  task automatic t_defaults;
    wait_cpu(1'b1);
    chk("pll", {pll_run, npwr, full, flash}, 4'hf);
    chk("front", {fclk, lclk, div_n, ext_n, alt_n}, 5'h00);
    chk("display_link_pll", {pd, lpd, loe_n, pwm}, 4'hf);
    chk("gpio", oe_n, {GP_PIN_COUNT{1'b1}});
    @(posedge mclk_in);
    {front_clk_en_in, lvds_power_on_in, periph_reset_release_in} <= 3'h7;
    gpio_release_in <= 1'b1;
    repeat (3) @(negedge mclk_in);
    // Link drivers stay powered down until the dividers run
    chk("enables", {fclk, lpd, per_n, alt_n}, 4'hf);
  endtask : t_defaults
  task automatic t_bringup;
    int i;
    @(posedge mclk_in);
    {divider_release_in, ext_reset_release_in} <= 2'h3;
    repeat (3) @(negedge mclk_in);
    chk("refused", {div_n, ext_n, lclk}, 3'h0);
    @(posedge mclk_in);
    {divider_release_in, ext_reset_release_in} <= 2'h0;
    display_link_pll_en_in <= 1'b1;
    for (i = 0; i < 50 && lock !== 1'b1; i++) @(posedge mclk_in);
    divider_release_in <= 1'b1;
    repeat (3) @(negedge mclk_in);
    chk("dividers", {pd, div_n, lclk, ext_n, lpd, loe_n}, 6'h18);
    @(posedge mclk_in);
    ext_reset_release_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    chk("ext", ext_n, 1'b1);
  endtask : t_bringup
  task automatic t_spread;
    logic [3:0] exp [4] = '{4'h0, SPREAD_DEPTH_HALF, SPREAD_DEPTH_FULL, 4'h0};
    logic [RAMP_W-1:0] pk;
    logic back;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_in);
      spread_sel_in <= 2'(k);
      repeat (2) @(negedge mclk_in);
      chk("depth", dep, exp[k]);
    end
    // One full triangle: up to the peak and back down to zero
    @(posedge mclk_in);
    spread_sel_in <= SPREAD_HALF;
    pk = '0;
    back = 1'b0;
    repeat (120) begin
      @(negedge mclk_in);
      if (ramp > pk) pk = ramp;
      if (pk == RAMP_PEAK_HALF && ramp == '0) back = 1'b1;
    end
    chk("ramp_peak", pk, RAMP_PEAK_HALF);
    chk("ramp_back", back, 1'b1);
  endtask : t_spread
  task automatic t_sources;
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_in);
      fw(1'b0);
      {watchdog_expired_in, lamp_strike_in} <= {k == 0, k == 1};
      power_good_input_in <= (k != 2);
      wait_cpu(1'b0);
      chk("in_rst", {pll_run, pd, loe_n, ext_n, div_n}, 5'h1c);
      @(posedge mclk_in);
      {watchdog_expired_in, lamp_strike_in, power_good_input_in} <= 3'h1;
      wait_cpu(1'b1);
      chk("normal", {npwr, pll_run, oe_n[0]}, 3'h7);
    end
  endtask : t_sources
  // Only a power-up reset may stop the primary PLL
  task automatic t_por;
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (2) @(negedge mclk_in);
    chk("por", {pll_run, npwr, cpu_n}, 3'h0);
    @(posedge mclk_in);
    nrst_in <= 1'b1;
    wait_cpu(1'b1);
    chk("por_up", {pll_run, npwr, oe_n[0]}, 3'h7);
  endtask : t_por
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    {err_total, n_checks, cycles} = '0;
    {nrst_in, watchdog_expired_in, lamp_strike_in} = 3'h0;
    power_good_input_in = 1'b1;
    spread_sel_in = 2'h0;
    fw(1'b0);
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_defaults();
    t_bringup();
    t_spread();
    t_sources();
    t_por();
    summarize();
  end
endmodule : reset_clock_bringup_tb
`default_nettype wire
